// file: hw/efcs_pkg.sv
// Constants, encodings and timing counts for the embedded flash command sequencer
package efcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and array timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned T_NVS_US = 5;
  localparam int unsigned T_PGS_US = 10;
  localparam int unsigned T_WRITE_PULSE_US = 30;
  localparam int unsigned T_PGH_NS = 20;
  localparam int unsigned T_NVH_US = 5;
  localparam int unsigned T_NVH_MASS_US = 100;
  localparam int unsigned T_RCV_US = 1;
  localparam int unsigned T_ERASE_MS = 3;

  localparam int unsigned NVS_CYC = T_NVS_US * CLK_MHZ;
  localparam int unsigned PGS_CYC = T_PGS_US * CLK_MHZ;
  localparam int unsigned WRITE_PULSE_CYC = T_WRITE_PULSE_US * CLK_MHZ;
  localparam int unsigned PGH_CYC = (T_PGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned NVH_CYC = T_NVH_US * CLK_MHZ;
  localparam int unsigned NVH_MASS_CYC = T_NVH_MASS_US * CLK_MHZ;
  localparam int unsigned RCV_CYC = T_RCV_US * CLK_MHZ;
  localparam int unsigned ERASE_CYC = T_ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_WRITE_PULSE_BYTE = 8'h80;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h20;
  localparam logic [7:0] CMD_READ_STATUS = 8'h10;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'hA0;
  localparam logic [7:0] CMD_MAIN_BLOCK = 8'hB0;
  localparam logic [7:0] CMD_INFO_BLOCK = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte layout and protection
  localparam int unsigned ST_BUSY = 7;
  localparam int unsigned ST_BAD_CMD = 6;
  localparam int unsigned ST_LOCK_ERR = 5;
  localparam int unsigned ST_SEQ_FAULT = 4;
  localparam int unsigned ST_INFO = 3;
  localparam int unsigned ST_LOCK = 2;
  localparam logic [15:0] BOOT_LIMIT = 16'h0800;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // State and operation encodings
  typedef enum logic [1:0] {
    H_ARRAY = 2'b00,
    H_STATUS = 2'b01,
    H_ARG = 2'b11,
    H_BUSY = 2'b10
  } efcs_host_t;

  typedef enum logic [2:0] {
    F_IDLE = 3'b000,
    F_NVS = 3'b001,
    F_PGS = 3'b011,
    F_OP = 3'b010,
    F_PGH = 3'b110,
    F_NVH = 3'b111,
    F_RCV = 3'b101
  } efcs_flash_t;

  typedef enum logic [1:0] {
    OP_WRITE_PULSE = 2'b00,
    OP_PAGE = 2'b01,
    OP_MASS = 2'b10
  } efcs_op_t;

endpackage

// file: hw/efcs_sequencer.sv
// Embedded flash command sequencer: host command handling and array strobe sequencing
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// (RULE1) Host command handling and array sequencing run as separate concurrent processes.
// (RULE2) Array-read mode passes host address to array and array data to reads.
// (RULE3) Reset enters array-read mode; it stays until reset or a mode command.
// (RULE4) During array reads program, erase, whole-array and store strobes stay low.
// (RULE5) Writes in array-read or status-idle mode load the command register. The code does not load reserved codes into it.
// (RULE6) Byte program holds address and data from second write; sense stays low.
// (RULE7) Program: 5 us to store, 10 us to pulse, pulse 20 to 40 us.
// (RULE8) Page erase latches page address; only row enable pulses among enables.
// (RULE9) Page erase: 5 us setup, 2-4 ms erase, 5 us hold, 1 us recovery.
// (RULE10) Mass erase: enables low, 2-4 ms erase, 100 us hold, 1 us recovery; row enable stays high until the store hold.
// (RULE11) After program or erase both processes idle until the next command.
// (RULE12) Read-status mode returns status on reads, array detached and in standby.
// (RULE13) Clear-status clears error flags, detaches array, idles in status mode.
// (RULE14) Select-main clears info flag, detaches array, idles in status mode.
// (RULE15) Select-info sets info flag, detaches array, idles in status mode.
// (RULE16) Writes while busy are dropped, command kept, bad-command flag set.
// (RULE17) Reserved code while idle sets bad-command flag and goes idle.
// (RULE18) Program or erase on protected memory is refused with locked-region flag.
// (RULE19) Read instead of argument write aborts, sets sequence-fault flag, goes idle.
// (RULE20) Busy rises after argument cycle, falls after store drop plus recovery.
// (RULE21) Status: busy 7, bad 6, locked 5, fault 4, info 3, lock 2.
// (RULE22) Host clears error flags with clear-status before issuing further commands.
// (RULE23) Host sends the argument write right after a one-cycle command code.
// (RULE24) Intervals are counted in clock cycles derived from the clock rate.
module efcs_sequencer
  import efcs_pkg::*;
#(
  parameter int unsigned P_WRITE_PULSE_CYC = efcs_pkg::WRITE_PULSE_CYC,
  parameter int unsigned P_ERASE_CYC = efcs_pkg::ERASE_CYC,
  parameter int unsigned P_NVH_MASS_CYC = efcs_pkg::NVH_MASS_CYC
) (
  input wire logic core_clk, // System clock
  input wire logic srst, // Synchronous reset, high
  input wire logic [15:0] host_addr, // Host address
  input wire logic [7:0] host_wdata, // Host write data
  input wire logic host_wr, // Host write strobe
  input wire logic host_rd, // Host read strobe
  output logic [7:0] host_rdata, // Read data, cycle after strobe
  input wire logic write_protect_n, // Boot block protect, low locks
  output logic busy, // Program or erase running
  output logic [15:0] arr_addr, // Array address
  output logic [7:0] arr_din, // Array program data
  input wire logic [7:0] arr_dout, // Array read data
  output logic info_select, // Information block selected
  output logic row_enable, // Array row enable
  output logic column_enable, // Array column enable
  output logic sense_amp_enable, // Array sense amplifier enable
  output logic read_drive_enable, // Array output drive enable
  output logic write_pulse, // Array program strobe
  output logic erase, // Array erase strobe
  output logic whole_array_select, // Whole array erase select
  output logic high_voltage_store // Array high voltage store
);
  import efcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Host side state
  efcs_host_t h_r, h_nxt;
  efcs_op_t op_r, op_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic info_r, info_nxt;
  logic busy_r, busy_nxt;
  logic bad_r, bad_nxt;
  logic lock_err_r, lock_err_nxt;
  logic seq_r, seq_nxt;
  logic launch_r, launch_nxt;
  logic locked;
  logic [7:0] status;

  ////////////////////////////////////////////////////////////////////////////
  // Array side state
  efcs_flash_t f_r, f_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic flash_done;
  logic is_write_pulse;
  logic is_mass;
  logic hv_span;

  // Boot block guard covers the main block only
  function automatic logic protected_addr(input logic [15:0] a, input logic lk, input logic inf);
    protected_addr = lk && !inf && (a < BOOT_LIMIT);
  endfunction

  function automatic logic [CNT_W-1:0] dur(input efcs_flash_t s, input efcs_op_t op);
    int unsigned c;
    c = 1;
    unique case (s)
      F_NVS: c = NVS_CYC;
      F_PGS: c = PGS_CYC;
      F_OP: c = (op == OP_WRITE_PULSE) ? P_WRITE_PULSE_CYC : P_ERASE_CYC;
      F_PGH: c = PGH_CYC;
      F_NVH: c = (op == OP_MASS) ? P_NVH_MASS_CYC : NVH_CYC;
      F_RCV: c = RCV_CYC;
      F_IDLE: c = 1;
      default: c = 1;
    endcase
    dur = CNT_W'(c - 1); // RULE24
  endfunction

  assign locked = !write_protect_n;
  // Host side leaves busy only once recovery has run out
  assign flash_done = (f_r == F_RCV) && (cnt_r == '0);

  always_comb begin
    status = 8'h00; // RULE21
    status[ST_BUSY] = busy_r;
    status[ST_BAD_CMD] = bad_r;
    status[ST_LOCK_ERR] = lock_err_r;
    status[ST_SEQ_FAULT] = seq_r;
    status[ST_INFO] = info_r;
    status[ST_LOCK] = locked;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host interface process
  always_comb begin
    h_nxt = h_r;
    op_nxt = op_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    rdata_nxt = rdata_r;
    info_nxt = info_r;
    busy_nxt = busy_r;
    bad_nxt = bad_r;
    lock_err_nxt = lock_err_r;
    seq_nxt = seq_r;
    launch_nxt = 1'b0;
    if (flash_done) begin
      busy_nxt = 1'b0; // RULE20
      h_nxt = H_STATUS; // RULE11
    end
    // A read that aborts an argument wait returns the pre-fault status
    if (host_rd) begin
      rdata_nxt = (h_r == H_ARRAY) ? arr_dout : status; // RULE2 RULE12
    end
    if (host_wr && busy_r) begin
      bad_nxt = 1'b1; // RULE16
    end else if (host_wr && h_r == H_ARG) begin
      addr_nxt = host_addr; // RULE6 RULE8
      data_nxt = host_wdata;
      op_nxt = (cmd_r == CMD_WRITE_PULSE_BYTE) ? OP_WRITE_PULSE : OP_PAGE;
      if (protected_addr(host_addr, locked, info_r)) begin
        lock_err_nxt = 1'b1; // RULE18
        h_nxt = H_STATUS;
      end else begin
        busy_nxt = 1'b1; // RULE20
        // Busy leads the array strobes by one cycle
        launch_nxt = 1'b1;
        h_nxt = H_BUSY;
      end
    end else if (host_wr) begin
      h_nxt = H_STATUS; // RULE5
      unique case (host_wdata)
        CMD_READ_ARRAY: begin
          cmd_nxt = host_wdata;
          h_nxt = H_ARRAY;
        end
        CMD_WRITE_PULSE_BYTE, CMD_PAGE_ERASE: begin
          cmd_nxt = host_wdata;
          h_nxt = H_ARG;
        end
        CMD_MASS_ERASE: begin
          cmd_nxt = host_wdata;
          op_nxt = OP_MASS;
          if (locked) begin
            lock_err_nxt = 1'b1; // RULE18
          end else begin
            busy_nxt = 1'b1; // RULE20
            launch_nxt = 1'b1;
            h_nxt = H_BUSY;
          end
        end
        CMD_READ_STATUS: begin
          cmd_nxt = host_wdata; // RULE12
        end
        CMD_CLEAR_STATUS: begin
          cmd_nxt = host_wdata;
          bad_nxt = 1'b0; // RULE13
          lock_err_nxt = 1'b0;
          seq_nxt = 1'b0;
        end
        CMD_MAIN_BLOCK: begin
          cmd_nxt = host_wdata;
          info_nxt = 1'b0; // RULE14
        end
        CMD_INFO_BLOCK: begin
          cmd_nxt = host_wdata;
          info_nxt = 1'b1; // RULE15
        end
        default: begin
          bad_nxt = 1'b1; // RULE17
        end
      endcase
    end else if (host_rd && h_r == H_ARG) begin
      seq_nxt = 1'b1; // RULE19
      h_nxt = H_STATUS;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      h_r <= H_ARRAY; // RULE3
      op_r <= OP_WRITE_PULSE;
      cmd_r <= CMD_RESET;
      addr_r <= ADDR_RESET;
      data_r <= RDATA_RESET;
      rdata_r <= RDATA_RESET;
      info_r <= 1'b0;
      busy_r <= 1'b0;
      bad_r <= 1'b0;
      lock_err_r <= 1'b0;
      seq_r <= 1'b0;
      launch_r <= 1'b0;
    end else begin
      h_r <= h_nxt;
      op_r <= op_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      rdata_r <= rdata_nxt;
      info_r <= info_nxt;
      busy_r <= busy_nxt;
      bad_r <= bad_nxt;
      lock_err_r <= lock_err_nxt;
      seq_r <= seq_nxt;
      launch_r <= launch_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array interface process
  always_comb begin
    f_nxt = f_r; // RULE1
    unique case (f_r)
      F_IDLE: begin
        if (launch_r) begin
          f_nxt = F_NVS;
        end
      end
      F_NVS: begin
        if (cnt_r == '0) begin
          f_nxt = (op_r == OP_WRITE_PULSE) ? F_PGS : F_OP; // RULE7 RULE9
        end
      end
      F_PGS: begin
        if (cnt_r == '0) begin
          f_nxt = F_OP; // RULE7
        end
      end
      F_OP: begin
        if (cnt_r == '0) begin
          f_nxt = (op_r == OP_WRITE_PULSE) ? F_PGH : F_NVH; // RULE9 RULE10
        end
      end
      F_PGH: begin
        if (cnt_r == '0) begin
          f_nxt = F_NVH;
        end
      end
      F_NVH: begin
        if (cnt_r == '0) begin
          f_nxt = F_RCV; // RULE10
        end
      end
      F_RCV: begin
        if (cnt_r == '0) begin
          f_nxt = F_IDLE; // RULE11
        end
      end
      // Unused code falls back to idle
      default: begin
        f_nxt = F_IDLE;
      end
    endcase
    if (f_nxt != f_r) begin
      cnt_nxt = dur(f_nxt, op_r); // RULE24
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      f_r <= F_IDLE;
      cnt_r <= '0;
    end else begin
      f_r <= f_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array strobes
  assign is_write_pulse = (op_r == OP_WRITE_PULSE);
  assign is_mass = (op_r == OP_MASS);
  assign hv_span = (f_r != F_IDLE) && (f_r != F_RCV);

  always_comb begin
    row_enable = 1'b0;
    column_enable = 1'b0;
    sense_amp_enable = 1'b0; // RULE6
    read_drive_enable = 1'b0;
    write_pulse = 1'b0;
    erase = 1'b0;
    whole_array_select = 1'b0;
    high_voltage_store = 1'b0;
    if (h_r == H_ARRAY) begin
      row_enable = host_rd; // RULE4
      column_enable = host_rd;
      sense_amp_enable = host_rd;
      read_drive_enable = host_rd;
    end else if (hv_span) begin
      // Row enable drops in the store hold only for mass erase
      row_enable = !is_mass || (f_r != F_NVH); // RULE8 RULE10
      column_enable = is_write_pulse && (f_r == F_OP); // RULE7
      write_pulse = is_write_pulse && (f_r != F_NVH); // RULE7
      erase = !is_write_pulse && (f_r == F_NVS || f_r == F_OP); // RULE9 RULE10
      whole_array_select = is_mass; // RULE10
      high_voltage_store = (f_r != F_NVS); // RULE7 RULE9
    end
  end

  assign arr_addr = (h_r == H_ARRAY) ? host_addr : addr_r; // RULE2
  assign arr_din = data_r;
  assign info_select = info_r;
  assign busy = busy_r;
  assign host_rdata = rdata_r;

endmodule

`default_nettype wire

// file: tb/efcs_sequencer_assertions.sv
// Port checks for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module efcs_sequencer_assertions
  import efcs_pkg::*;
#(
  parameter int unsigned P_WRITE_PULSE_CYC = 20,
  parameter int unsigned P_ERASE_CYC = 50
) (
  input wire logic core_clk, // Clock
  input wire logic srst, // Reset
  input wire logic host_wr, // Write strobe
  input wire logic busy, // Busy
  input wire logic info_select, // Block
  input wire logic row_enable, // Row
  input wire logic column_enable, // Column
  input wire logic sense_amp_enable, // Sense
  input wire logic read_drive_enable, // Drive
  input wire logic write_pulse, // Program
  input wire logic erase, // Erase
  input wire logic whole_array_select, // Whole
  input wire logic high_voltage_store // Store
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [CNT_W-1:0] set_r, set_nxt, rcv_r, rcv_nxt, len_r, len_nxt, ers_r, ers_nxt;
  always_comb begin
    set_nxt = (write_pulse | erase) ? set_r + 1'b1 : '0;
    rcv_nxt = high_voltage_store ? '0 : ((&rcv_r) ? rcv_r : rcv_r + 1'b1);
    len_nxt = (column_enable & write_pulse) ? len_r + 1'b1 : '0;
    ers_nxt = (erase & high_voltage_store) ? ers_r + 1'b1 : '0;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      set_r <= '0;
      rcv_r <= '0;
      len_r <= '0;
      ers_r <= '0;
    end else begin
      set_r <= set_nxt;
      rcv_r <= rcv_nxt;
      len_r <= len_nxt;
      ers_r <= ers_nxt;
    end
  end
  chk_idle_strobes: assert property (!busy |-> !(write_pulse | erase | whole_array_select | high_voltage_store))
    else $error("array strobe active while not busy");
  chk_write_pulse_sense: assert property (write_pulse |-> !sense_amp_enable)
    else $error("sense enabled during program");
  chk_erase_enables: assert property (erase |-> !(column_enable | sense_amp_enable | read_drive_enable))
    else $error("read path enabled during erase");
  chk_row_span: assert property ((write_pulse | erase) |-> row_enable)
    else $error("row enable low during program or erase");
  chk_store_setup: assert property ($rose(high_voltage_store) |-> set_r >= NVS_CYC)
    else $error("store set up too short");
  chk_write_pulse_len: assert property ($fell(column_enable) && write_pulse |-> len_r == P_WRITE_PULSE_CYC)
    else $error("program pulse length wrong");
  chk_erase_len: assert property ($fell(erase) && high_voltage_store |-> ers_r == P_ERASE_CYC)
    else $error("erase length wrong");
  chk_busy_recovery: assert property ($fell(busy) && !$past(srst) |-> rcv_r >= RCV_CYC - 1)
    else $error("busy fell before recovery");
  chk_busy_cause: assert property ($rose(busy) |-> $past(host_wr))
    else $error("busy rose without a write");
  chk_info_cause: assert property ($changed(info_select) && !$past(srst) |-> $past(host_wr) && !$past(busy))
    else $error("block select changed without command");
  cover property ($fell(busy));
  cover property ($rose(whole_array_select));
  cover property ($rose(info_select));
endmodule
`default_nettype wire

// file: tb/efcs_array_model.sv
// Behavioural flash array behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module efcs_array_model (
  input wire logic core_clk, // Clock
  input wire logic [15:0] arr_addr, // Address
  input wire logic info_select, // Block
  input wire logic read_drive_enable, // Output drive
  output logic [7:0] arr_dout // Read data
);
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge core_clk) last_r <= arr_dout;
  // Undriven bus shows the inverse of its last value
  assign arr_dout = read_drive_enable ? (arr_addr[15:8] ^ arr_addr[7:0] ^ {7'h00, info_select}) : ~last_r;
endmodule
`default_nettype wire

// file: tb/tb_efcs_sequencer.sv
// Testbench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_efcs_sequencer;
  import efcs_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] host_addr = 16'h0000;
  logic [7:0] host_wdata = 8'h00;
  logic host_wr = 1'b0, host_rd = 1'b0, write_protect_n = 1'b1;
  logic [7:0] host_rdata, arr_din, arr_dout, rv;
  logic [15:0] arr_addr;
  logic busy, info_select, row_enable, column_enable, sense_amp_enable, read_drive_enable;
  logic write_pulse, erase, whole_array_select, high_voltage_store;
  int err_count = 0;
  int total_checks = 0;
  efcs_sequencer #(.P_WRITE_PULSE_CYC(20), .P_ERASE_CYC(50), .P_NVH_MASS_CYC(30)) u_dut (.core_clk, .srst, .host_addr,
    .host_wdata, .host_wr, .host_rd, .host_rdata, .write_protect_n, .busy, .arr_addr, .arr_din, .arr_dout,
    .info_select, .row_enable, .column_enable, .sense_amp_enable, .read_drive_enable, .write_pulse, .erase,
    .whole_array_select, .high_voltage_store);
  efcs_array_model u_arr (.core_clk, .arr_addr, .info_select, .read_drive_enable, .arr_dout);
  initial forever #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Code write, optionally followed at once by the argument write
  task automatic wr(input logic [7:0] c, input bit arg = 1'b0, input logic [15:0] a = 16'h0000,
    input logic [7:0] d = 8'h00);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_wdata <= c;
    if (arg) begin
      @(posedge core_clk);
      host_addr <= a;
      host_wdata <= d;
    end
    @(posedge core_clk);
    host_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge core_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_rd <= 1'b0;
    #1 v = host_rdata;
  endtask
  task automatic st(input logic [7:0] e);
    rd(16'h0000, rv);
    chk(rv, e);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge core_clk);
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 20000) err_count++;
  endtask
  task automatic finish_test;
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    rd(16'h1234, rv);
    chk(rv, 8'h26);
    wr(CMD_READ_STATUS);
    st(8'h00);
    wr(8'h55);
    st(8'h40);
    wr(CMD_CLEAR_STATUS);
    st(8'h00);
    wr(CMD_INFO_BLOCK);
    st(8'h08);
    wr(CMD_MAIN_BLOCK);
    st(8'h00);
    wr(CMD_WRITE_PULSE_BYTE, 1'b1, 16'h1000, 8'hA5);
    @(negedge core_clk);
    chk(busy, 1'b1);
    chk(arr_addr, 16'h1000);
    chk(arr_din, 8'hA5);
    st(8'h80);
    wr(8'h00);
    wait_idle;
    st(8'h40);
    wr(CMD_CLEAR_STATUS);
    wr(CMD_PAGE_ERASE, 1'b1, 16'h2000);
    wait_idle;
    st(8'h00);
    wr(CMD_MASS_ERASE);
    wait_idle;
    st(8'h00);
    wr(CMD_WRITE_PULSE_BYTE);
    st(8'h00);
    st(8'h10);
    wr(CMD_CLEAR_STATUS);
    write_protect_n <= 1'b0;
    wr(CMD_PAGE_ERASE, 1'b1, 16'h0100);
    st(8'h24);
    wr(CMD_CLEAR_STATUS);
    wr(CMD_MASS_ERASE);
    st(8'h24);
    chk(busy, 1'b0);
    wr(CMD_CLEAR_STATUS);
    st(8'h04);
    wr(CMD_READ_ARRAY);
    write_protect_n <= 1'b1;
    rd(16'hABCD, rv);
    chk(rv, 8'h66);
    finish_test;
  end
endmodule
bind efcs_sequencer efcs_sequencer_assertions #(.P_WRITE_PULSE_CYC(P_WRITE_PULSE_CYC), .P_ERASE_CYC(P_ERASE_CYC)) u_chk (
  .core_clk, .srst, .host_wr, .busy, .info_select, .row_enable, .column_enable, .sense_amp_enable, .read_drive_enable,
  .write_pulse, .erase, .whole_array_select, .high_voltage_store);
`default_nettype wire
